// >>> dv/adc_serial_readout_tb.sv
// Self-checking bench for the serial readout block.
`timescale 1ns/1ps
module adc_serial_readout_tb;
   import adc_readout_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1;
   logic [11:0] conversion_result = 12'h000;
   logic chip_select_n, serial_clock, power_down_n, serial_data_out;
   logic serial_data_enable, converting, result_ready;
   logic [COUNT_WIDTH-1:0] bits_sent;
   int bad_count = 0, checks = 0;
   always #4 clock = ~clock;
   adc_serial_readout #(.CONV_CYCLES(20)) i_dut (.*);
   host_master i_host (.*);
   task automatic check(string w, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic read(int n, logic [11:0] v);
      conversion_result = v;
      i_host.read(n);
      check("start", 16'h0001, {15'h0000, i_host.ok});
      if (!i_host.ok) end_sim();
   endtask
   task automatic test_frames();
      logic [11:0] v [2] = '{12'ha5c, 12'h001};
      foreach (v[k]) begin
         read(16, v[k]);
         check("bytes", {1'b1, v[k], 3'h0}, i_host.word);
         check("justified", {4'h0, v[k]}, {4'h0, i_host.word[14:3]});
         read(13, v[k]);
         check("frame", {4'h1, v[k]}, i_host.word);
      end
   endtask
   task automatic test_abort();
      read(5, 12'hfff);
      i_host.pulse();
      check("abort", 16'h0000,
         {9'h000, serial_data_enable, serial_data_out, bits_sent});
      read(16, 12'hfff);
      check("rearm", {1'b1, 12'hfff, 3'h0}, i_host.word);
   endtask
   task automatic test_power();
      i_host.power_down_n = 1'b0;
      repeat (4) @(posedge clock);
      #1 i_host.chip_select_n = 1'b0;
      repeat (40) @(posedge clock);
      #1 check("powered down", 16'h0000,
         {12'h000, serial_data_enable, serial_data_out,
          converting, result_ready});
      i_host.chip_select_n = 1'b1;
      i_host.power_down_n = 1'b1;
      repeat (8) @(posedge clock);
      #1 read(16, 12'h3c6);
      check("powered up", {1'b1, 12'h3c6, 3'h0}, i_host.word);
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1 sys_rst = 1'b0;
      repeat (4) @(posedge clock);
      #1 test_frames();
      test_abort();
      test_power();
      end_sim();
   end
endmodule

// >>> dv/host_master.sv
// Host serial master model for mode 0 readouts.
`timescale 1ns/1ps
module host_master (
   input logic clock,
   input logic serial_data_out,
   input logic serial_data_enable,
   output logic chip_select_n,
   output logic serial_clock,
   output logic power_down_n
);
   logic [15:0] word;
   bit ok;
   wire line;
   // A released line is shown inverted, so a read of a floating pin shows.
   assign line = serial_data_enable ? serial_data_out : !serial_data_out;
   initial {chip_select_n, serial_clock, power_down_n} = 3'b101;
   // Half of an 80 ns link period; the clock rests low between frames.
   task automatic half();
      repeat (5) @(posedge clock);
      #1;
   endtask
   task automatic pulse();
      half();
      serial_clock = 1'b1;
      word = {word[14:0], line};
      half();
      serial_clock = 1'b0;
   endtask
   task automatic read(int nbits);
      word = 16'h0000;
      ok = 1'b0;
      chip_select_n = 1'b0;
      for (int n = 0; n < 400 && !ok; n++) begin
         half();
         ok = line;
      end
      for (int i = 0; i < nbits && ok; i++)
         pulse();
      half();
      chip_select_n = 1'b1;
      half();
   endtask
endmodule

// >>> dv/readout_checker_assertions.sv
// Checker for the readout block's ports.
`timescale 1ns/1ps
module readout_checker #(parameter int CONV_CYCLES = 20) (
   input logic clock,
   input logic sys_rst,
   input logic power_down_n,
   input logic chip_select_n,
   input logic serial_clock,
   input logic serial_data_out,
   input logic serial_data_enable,
   input logic converting,
   input logic result_ready,
   input logic [adc_readout_pkg::COUNT_WIDTH-1:0] bits_sent
);
   int conv_len;
   always_ff @(posedge clock)
      conv_len <= (sys_rst || !converting) ? 0 : conv_len + 1;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // A select fall while powered up must start a conversion within two to four cycles.
   conv_start_a: assert property ($fell(chip_select_n)
      && power_down_n |-> ##[2:4] converting) else $error("no conversion");
   start_bit_a: assert property ($rose(result_ready)
      |-> serial_data_out && !converting) else $error("no start bit");
   // Converting drops in the cycle the start bit is driven.
   conv_time_a: assert property ($rose(result_ready)
      |-> conv_len == CONV_CYCLES - 1) else $error("conversion time");
   idle_out_a: assert property (chip_select_n [*6]
      |-> !serial_data_enable && !serial_data_out) else $error("drives");
   count_hold_a: assert property (chip_select_n [*8]
      |-> $stable(bits_sent)) else $error("counts idle");
   count_step_a: assert property ($changed(bits_sent)
      |-> bits_sent == 5'h00 || bits_sent == $past(bits_sent) + 5'h01)
      else $error("count jumped");
   clock_count_a: assert property ($rose(serial_clock)
      && !chip_select_n && bits_sent < 5'h10 |-> ##[2:4] $changed(bits_sent))
      else $error("rise lost");
   hold_bit_a: assert property ($rose(serial_clock) && !chip_select_n
      |=> $stable(serial_data_out) [*4]) else $error("bit moved");
   drive_on_a: assert property ((!chip_select_n && power_down_n) [*4]
      |-> serial_data_enable) else $error("not driving");
   cover property ($rose(result_ready));
   cover property (bits_sent == 5'h10);
   cover property (bits_sent == 5'h0d);
endmodule
bind adc_serial_readout readout_checker
   #(.CONV_CYCLES(CONV_CYCLES)) i_check (.*);

// >>> logic/adc_readout_pkg.sv
// Constants and types shared by the serial readout design.
// Summary of operation
// - A falling edge on chip_select_n begins a new conversion.
// - At conversion end drive a high start bit, then result bits.
// - Data is shifted out on the host-driven serial clock only.
// - First eight bits: start bit, then result bits 11 down to 5.
// - Second eight bits: result bits 4 down to 0, then three zeros.
package adc_readout_pkg;

   localparam int RESULT_WIDTH = 12;
   localparam int TRAIL_ZEROS = 3;
   localparam int FRAME_BITS = 1 + RESULT_WIDTH + TRAIL_ZEROS;
   localparam int COUNT_WIDTH = 5;

   // Longest conversion time, in nanoseconds, and the clock period.
   localparam int CONVERSION_TIME_NS = 8500;
   localparam int CLOCK_PERIOD_NS = 8;
   // A longest time rounds down to whole cycles.
   localparam int CONVERSION_CYCLES = CONVERSION_TIME_NS / CLOCK_PERIOD_NS;
   localparam int CONV_COUNT_WIDTH = 11;

   localparam logic START_BIT = 1'b1;
   localparam logic IDLE_LEVEL = 1'b0;
   localparam logic [TRAIL_ZEROS-1:0] TRAIL_PATTERN = 3'h0;
   localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 5'h00;
   localparam logic [CONV_COUNT_WIDTH-1:0] CONV_ZERO = 11'h000;

   // Index of each pin input in the synchroniser bank.
   localparam int SYNC_SELECT = 0;
   localparam int SYNC_CLOCK = 1;
   localparam int SYNC_POWER = 2;
   localparam int SYNC_COUNT = 3;

   typedef enum logic [1:0] {
      STATE_IDLE = 2'b00,
      STATE_CONVERT = 2'b01,
      STATE_SHIFT = 2'b10,
      STATE_DONE = 2'b11
   } readout_state_type;

endpackage

// >>> logic/adc_serial_readout.sv
// Converter side of the serial readout: conversion timing and bit shifter.
`timescale 1ns/1ps
module adc_serial_readout
   import adc_readout_pkg::*;
#(
   parameter int CONV_CYCLES = adc_readout_pkg::CONVERSION_CYCLES,
   parameter int DATA_WIDTH = adc_readout_pkg::RESULT_WIDTH
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic power_down_n,
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic [DATA_WIDTH-1:0] conversion_result,
   output logic serial_data_out,
   output logic serial_data_enable,
   output logic converting,
   output logic result_ready,
   output logic [adc_readout_pkg::COUNT_WIDTH-1:0] bits_sent
);
   import adc_readout_pkg::*;

   // ***************************************************************
   // Pin synchronisation
   // ***************************************************************

   logic [SYNC_COUNT-1:0] pins_raw;
   logic [SYNC_COUNT-1:0] pins_reset;
   logic [SYNC_COUNT-1:0] pins_sync;
   logic select_n_sync;
   logic sclk_sync;
   logic power_sync;

   assign pins_raw[SYNC_SELECT] = chip_select_n;
   assign pins_raw[SYNC_CLOCK] = serial_clock;
   assign pins_raw[SYNC_POWER] = power_down_n;
   assign pins_reset[SYNC_SELECT] = 1'b1;
   assign pins_reset[SYNC_CLOCK] = 1'b0;
   assign pins_reset[SYNC_POWER] = 1'b0;

   pin_synchroniser #(
      .WIDTH(SYNC_COUNT)
   ) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin_in(pins_raw),
      .reset_level(pins_reset),
      .pin_sync(pins_sync)
   );

   assign select_n_sync = pins_sync[SYNC_SELECT];
   assign sclk_sync = pins_sync[SYNC_CLOCK];
   assign power_sync = pins_sync[SYNC_POWER];

   // ***************************************************************
   // Edge detection
   // ***************************************************************

   logic select_n_prev;
   logic sclk_prev;
   logic select_fall;
   logic sclk_fall;
   logic sclk_rise;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         select_n_prev <= 1'b1;
         sclk_prev <= 1'b0;
      end else begin
         select_n_prev <= select_n_sync;
         sclk_prev <= sclk_sync;
      end
   end

   assign select_fall = select_n_prev && !select_n_sync;
   // Clock edges count only while select is low, whatever the power-down pin.
   assign sclk_fall = sclk_prev && !sclk_sync && !select_n_sync;
   assign sclk_rise = !sclk_prev && sclk_sync && !select_n_sync;

   // ***************************************************************
   // Readout sequence
   // ***************************************************************

   readout_state_type state;
   logic [CONV_COUNT_WIDTH-1:0] conv_count;
   logic [FRAME_BITS-2:0] shift_data;
   logic conv_finished;

   assign conv_finished =
      (conv_count == CONV_COUNT_WIDTH'(CONV_CYCLES - 1));

   // Power-down or a raised select abandons whatever is in flight.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= STATE_IDLE;
      end else if (!power_sync) begin
         state <= STATE_IDLE;
      end else if (select_n_sync) begin
         state <= STATE_IDLE;
      end else begin
         case (state)
            STATE_IDLE: begin
               if (select_fall) begin
                  state <= STATE_CONVERT;
               end
            end
            STATE_CONVERT: begin
               if (conv_finished) begin
                  state <= STATE_SHIFT;
               end
            end
            STATE_SHIFT: begin
               if (sclk_fall &&
                   bits_sent == COUNT_WIDTH'(FRAME_BITS - 1)) begin
                  state <= STATE_DONE;
               end
            end
            STATE_DONE: begin
               state <= STATE_DONE;
            end
            default: begin
               state <= STATE_IDLE;
            end
         endcase
      end
   end

   // Conversion timer.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         conv_count <= CONV_ZERO;
      end else if (state == STATE_CONVERT && power_sync && !select_n_sync) begin
         conv_count <= conv_count + CONV_COUNT_WIDTH'(1);
      end else begin
         conv_count <= CONV_ZERO;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         converting <= 1'b0;
      end else begin
         converting <= (state == STATE_CONVERT) && !conv_finished
            && power_sync && !select_n_sync;
      end
   end

   // ***************************************************************
   // Output shifter
   // ***************************************************************

   // Mode 0 timing: the host samples on its rising edge, so the next bit
   // is placed after each falling edge. The start bit appears as soon as
   // the conversion ends, which lets a polling host see the line rise.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         serial_data_out <= IDLE_LEVEL;
         shift_data <= '0;
      end else if (!power_sync || select_n_sync) begin
         serial_data_out <= IDLE_LEVEL;
         shift_data <= '0;
      end else if (state == STATE_CONVERT && conv_finished) begin
         serial_data_out <= START_BIT;
         shift_data <= {conversion_result, TRAIL_PATTERN};
      end else if (state == STATE_SHIFT && sclk_fall) begin
         // The three trailing zeros come from TRAIL_PATTERN, loaded behind the result.
         serial_data_out <= shift_data[FRAME_BITS-2];
         shift_data <= {shift_data[FRAME_BITS-3:0], 1'b0};
      end
   end

   // Drive is only wanted while selected; the pin floats otherwise.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         serial_data_enable <= 1'b0;
      end else begin
         serial_data_enable <= power_sync && !select_n_sync;
      end
   end

   // Number of bits the host has taken, counted on its rising edges.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bits_sent <= COUNT_ZERO;
      end else if (state != STATE_SHIFT && state != STATE_DONE) begin
         bits_sent <= COUNT_ZERO;
      end else if (sclk_rise && bits_sent != COUNT_WIDTH'(FRAME_BITS)) begin
         bits_sent <= bits_sent + COUNT_WIDTH'(1);
      end
   end

   // Result ready from conversion end until the readout is abandoned.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         result_ready <= 1'b0;
      end else if (!power_sync || select_n_sync) begin
         result_ready <= 1'b0;
      end else if (state == STATE_CONVERT && conv_finished) begin
         result_ready <= 1'b1;
      end
   end

endmodule

// >>> logic/pin_synchroniser.sv
// Two-stage synchroniser bank for pins from outside the clock domain.
`timescale 1ns/1ps
module pin_synchroniser #(
   parameter int WIDTH = 3
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] reset_level,
   output logic [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] first_stage;

   // The first stage feeds only the second stage, nothing else.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : gen_sync
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               first_stage[i] <= reset_level[i];
               pin_sync[i] <= reset_level[i];
            end else begin
               first_stage[i] <= pin_in[i];
               pin_sync[i] <= first_stage[i];
            end
         end
      end
   endgenerate

endmodule
